// ==== hw/pis_pkg.sv ====
// Package: register map, field layout and types for persistent irq sources
package pis_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h0c;
    localparam logic [7:0] ADDR_CAP_BUF = 8'h10;
    localparam logic [7:0] ADDR_SYNC_BUF = 8'h14;
    localparam logic [7:0] ADDR_ASYNC_RX = 8'h18;
    localparam logic [7:0] ADDR_ASYNC_TX = 8'h1c;
    localparam logic [7:0] ADDR_CONV_RES = 8'h20;
    localparam logic [7:0] ADDR_PAR_DATA = 8'h24;
    localparam logic [7:0] ADDR_LEVELS = 8'h28;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_CAP_THR_LSB = 0;
    localparam int CTRL_SRX_SEL_LSB = 2;
    localparam int CTRL_STX_SEL_LSB = 4;
    localparam int CTRL_URX_SEL_LSB = 6;
    localparam int CTRL_UTX_SEL_LSB = 8;
    localparam int CTRL_ASYNC_EN_BIT = 10;
    localparam logic [10:0] CTRL_RESET = 11'h000;

    // Buffers are four deep; counts are three bits wide
    localparam int DEPTH = 4;
    localparam logic [2:0] CNT_MAX = 3'h4;
    localparam int NUM_SRC = 7;
    localparam logic [6:0] IRQ_EN_RESET = 7'h00;

    // Status / enable / clear bit positions
    localparam int IRQ_CAP = 0;
    localparam int IRQ_SRX = 1;
    localparam int IRQ_STX = 2;
    localparam int IRQ_URX = 3;
    localparam int IRQ_UTX = 4;
    localparam int IRQ_CONV = 5;
    localparam int IRQ_PAR = 6;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } pis_bus_req_t;

    // Hardware-side buffer events from the peripherals
    typedef struct packed {
        logic cap_push;
        logic srx_push;
        logic stx_pop;
        logic urx_push;
        logic utx_pop;
        logic conv_done;
        logic par_done;
    } pis_hw_evt_t;

endpackage : pis_pkg

// ==== hw/pis_irq_sources.sv ====
// Persistent level interrupt sources with sticky pending flags
`timescale 1ns/1ps
module pis_irq_sources (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire pis_pkg::pis_bus_req_t i_bus,
    output logic [31:0] o_rdata,
    input wire pis_pkg::pis_hw_evt_t i_evt,
    input wire logic [2:0] i_conv_samples,
    output logic o_irq
);

    // ------------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------------
    logic wr_ctrl, wr_en, wr_clr;
    logic rd_cap, acc_sync, rd_urx, wr_utx, rd_conv, rd_par;
    assign wr_ctrl = i_bus.wr && i_bus.addr == pis_pkg::ADDR_CTRL;
    assign wr_en = i_bus.wr && i_bus.addr == pis_pkg::ADDR_IRQ_EN;
    assign wr_clr = i_bus.wr && i_bus.addr == pis_pkg::ADDR_IRQ_CLR;
    assign rd_cap = i_bus.rd && i_bus.addr == pis_pkg::ADDR_CAP_BUF;
    assign acc_sync = (i_bus.rd || i_bus.wr)
        && i_bus.addr == pis_pkg::ADDR_SYNC_BUF;
    assign rd_urx = i_bus.rd && i_bus.addr == pis_pkg::ADDR_ASYNC_RX;
    assign wr_utx = i_bus.wr && i_bus.addr == pis_pkg::ADDR_ASYNC_TX;
    assign rd_conv = i_bus.rd && i_bus.addr == pis_pkg::ADDR_CONV_RES;
    assign rd_par = i_bus.rd && i_bus.addr == pis_pkg::ADDR_PAR_DATA;

    logic [10:0] ctrl_q;
    logic [6:0] en_q;
    logic [6:0] pend_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ctrl_q <= pis_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= i_bus.wdata[10:0];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            en_q <= pis_pkg::IRQ_EN_RESET;
        end else if (wr_en) begin
            en_q <= i_bus.wdata[6:0];
        end
    end

    logic [1:0] cap_thr, srx_sel, stx_sel, urx_sel, utx_sel;
    logic async_en;
    assign cap_thr = ctrl_q[pis_pkg::CTRL_CAP_THR_LSB +: 2];
    assign srx_sel = ctrl_q[pis_pkg::CTRL_SRX_SEL_LSB +: 2];
    assign stx_sel = ctrl_q[pis_pkg::CTRL_STX_SEL_LSB +: 2];
    assign urx_sel = ctrl_q[pis_pkg::CTRL_URX_SEL_LSB +: 2];
    assign utx_sel = ctrl_q[pis_pkg::CTRL_UTX_SEL_LSB +: 2];
    assign async_en = ctrl_q[pis_pkg::CTRL_ASYNC_EN_BIT];

    // ------------------------------------------------------------------
    // Buffer fill counters
    // ------------------------------------------------------------------
    // Saturating up/down counter; inc and dec in one cycle cancel
    function automatic logic [2:0] step(input logic [2:0] c,
                                        input logic inc,
                                        input logic dec);
        logic [2:0] n;
        n = c;
        if (inc && !dec && c != pis_pkg::CNT_MAX) begin
            n = c + 3'h1;
        end else if (dec && !inc && c != 3'h0) begin
            n = c - 3'h1;
        end
        return n;
    endfunction : step

    logic [2:0] cap_cnt_q, srx_cnt_q, stx_cnt_q, urx_cnt_q, utx_cnt_q;
    logic [2:0] conv_cnt_q;
    logic par_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cap_cnt_q <= 3'h0;
        end else begin
            cap_cnt_q <= step(cap_cnt_q, i_evt.cap_push, rd_cap);
        end
    end

    // A sync buffer read drains rx, a write fills tx
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            srx_cnt_q <= 3'h0;
            stx_cnt_q <= 3'h0;
        end else begin
            srx_cnt_q <= step(srx_cnt_q, i_evt.srx_push,
                              acc_sync && i_bus.rd);
            stx_cnt_q <= step(stx_cnt_q, acc_sync && i_bus.wr,
                              i_evt.stx_pop);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            urx_cnt_q <= 3'h0;
            utx_cnt_q <= 3'h0;
        end else begin
            urx_cnt_q <= step(urx_cnt_q, i_evt.urx_push, rd_urx);
            utx_cnt_q <= step(utx_cnt_q, wr_utx, i_evt.utx_pop);
        end
    end

    // Converter reloads the full sample count on each completed sequence
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            conv_cnt_q <= 3'h0;
        end else if (i_evt.conv_done) begin
            conv_cnt_q <= i_conv_samples;
        end else if (rd_conv && conv_cnt_q != 3'h0) begin
            conv_cnt_q <= conv_cnt_q - 3'h1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            par_q <= 1'b0;
        end else if (i_evt.par_done) begin
            par_q <= 1'b1;
        end else if (rd_par) begin
            par_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Source conditions
    // ------------------------------------------------------------------
    // Threshold select: level = sel + 1 for receive-like buffers
    function automatic logic rx_cond(input logic [2:0] c,
                                     input logic [1:0] sel);
        return c >= ({1'b0, sel} + 3'h1);
    endfunction : rx_cond

    // Transmit: source while free space reaches sel + 1 entries
    function automatic logic tx_cond(input logic [2:0] c,
                                     input logic [1:0] sel);
        return (pis_pkg::CNT_MAX - c) >= ({1'b0, sel} + 3'h1);
    endfunction : tx_cond

    logic [6:0] src;
    always_comb begin
        src = '0;
        src[pis_pkg::IRQ_CAP] = rx_cond(cap_cnt_q, cap_thr);
        src[pis_pkg::IRQ_SRX] = rx_cond(srx_cnt_q, srx_sel);
        src[pis_pkg::IRQ_STX] = tx_cond(stx_cnt_q, stx_sel);
        src[pis_pkg::IRQ_URX] = async_en && rx_cond(urx_cnt_q, urx_sel);
        // Empty tx buffer meets the condition as soon as enabled
        src[pis_pkg::IRQ_UTX] = async_en && tx_cond(utx_cnt_q, utx_sel);
        src[pis_pkg::IRQ_CONV] = conv_cnt_q != 3'h0;
        src[pis_pkg::IRQ_PAR] = par_q;
    end

    // ------------------------------------------------------------------
    // Pending flags
    // ------------------------------------------------------------------
    logic [6:0] clr_mask;
    assign clr_mask = {7{wr_clr}} & i_bus.wdata[6:0];

    // Source wins over a clear, so a live condition cannot be cleared
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pend_q <= '0;
        end else begin
            pend_q <= src | (pend_q & ~clr_mask);
        end
    end

    assign o_irq = |(pend_q & en_q);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_bus.rd) begin
            unique case (i_bus.addr)
                pis_pkg::ADDR_CTRL: o_rdata <= {21'h0, ctrl_q};
                pis_pkg::ADDR_STATUS: o_rdata <= {25'h0, pend_q};
                pis_pkg::ADDR_IRQ_EN: o_rdata <= {25'h0, en_q};
                pis_pkg::ADDR_LEVELS: o_rdata <= {14'h0, conv_cnt_q,
                    utx_cnt_q, urx_cnt_q, stx_cnt_q, srx_cnt_q, cap_cnt_q};
                default: o_rdata <= 32'h0;
            endcase
        end else begin
            o_rdata <= 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_clear_attempt(int b);
        wr_clr && i_bus.wdata[b] && src[b];
    endsequence

    // A lone pop with entries left takes exactly one away
    sequence s_cap_pop;
        rd_cap && !i_evt.cap_push && cap_cnt_q != 3'h0;
    endsequence

    sequence s_srx_pop;
        acc_sync && i_bus.rd && !i_evt.srx_push && srx_cnt_q != 3'h0;
    endsequence

    // Saturation keeps a stray pop or push from wrapping a count
    AST_CNT_RANGE: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        cap_cnt_q <= pis_pkg::CNT_MAX && srx_cnt_q <= pis_pkg::CNT_MAX
        && stx_cnt_q <= pis_pkg::CNT_MAX && urx_cnt_q <= pis_pkg::CNT_MAX
        && utx_cnt_q <= pis_pkg::CNT_MAX)
        else $error("buffer count above depth");

    AST_CAP_SRC: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (cap_cnt_q > {1'b0, cap_thr}) |-> src[pis_pkg::IRQ_CAP])
        else $error("capture source missing at threshold");
    AST_CAP_HOLD: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        src[pis_pkg::IRQ_CAP] && !rd_cap && !wr_ctrl
        |=> src[pis_pkg::IRQ_CAP])
        else $error("capture source dropped without read");
    AST_CAP_POP: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        s_cap_pop |=> cap_cnt_q == $past(cap_cnt_q) - 3'h1)
        else $error("capture read did not pop one entry");

    AST_SRX_SRC: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (srx_cnt_q <= {1'b0, srx_sel}) |-> !src[pis_pkg::IRQ_SRX])
        else $error("sync rx source below level");
    AST_SYNC_HOLD: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        src[pis_pkg::IRQ_SRX] && !acc_sync && !wr_ctrl
        |=> src[pis_pkg::IRQ_SRX])
        else $error("sync rx source dropped without access");
    AST_SRX_POP: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        s_srx_pop |=> srx_cnt_q == $past(srx_cnt_q) - 3'h1)
        else $error("sync buffer read did not pop one byte");
    AST_STX_SRC: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (pis_pkg::CNT_MAX - stx_cnt_q) > {1'b0, stx_sel}
        |-> src[pis_pkg::IRQ_STX])
        else $error("sync tx source missing with free space");
    AST_STX_HOLD: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        src[pis_pkg::IRQ_STX] && !(acc_sync && i_bus.wr) && !wr_ctrl
        |=> src[pis_pkg::IRQ_STX])
        else $error("sync tx source dropped without write");

    AST_UTX_ENABLE: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        wr_ctrl && i_bus.wdata[pis_pkg::CTRL_ASYNC_EN_BIT]
        && utx_cnt_q == 3'h0 && !wr_utx |=> ##1 pend_q[pis_pkg::IRQ_UTX])
        else $error("async tx flag not set after enable");
    AST_UTX_SRC: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        async_en && utx_cnt_q == 3'h0 |-> src[pis_pkg::IRQ_UTX])
        else $error("async tx source missing with empty buffer");
    AST_URX_GATE: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        !async_en |-> !src[pis_pkg::IRQ_URX])
        else $error("async rx source while disabled");
    AST_UTX_GATE: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        !async_en |-> !src[pis_pkg::IRQ_UTX])
        else $error("async tx source while disabled");
    AST_URX_SRC: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        async_en && urx_cnt_q > {1'b0, urx_sel} |-> src[pis_pkg::IRQ_URX])
        else $error("async rx source missing at level");
    AST_URX_HOLD: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        src[pis_pkg::IRQ_URX] && !rd_urx && !wr_ctrl
        |=> src[pis_pkg::IRQ_URX])
        else $error("async rx source dropped without read");
    AST_UTX_HOLD: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        src[pis_pkg::IRQ_UTX] && !wr_utx && !wr_ctrl
        |=> src[pis_pkg::IRQ_UTX])
        else $error("async tx source dropped without write");

    AST_CONV_HOLD: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (conv_cnt_q > 3'h1) && !i_evt.conv_done
        |=> src[pis_pkg::IRQ_CONV])
        else $error("converter source dropped with samples left");
    AST_CONV_LOAD: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        i_evt.conv_done |=> conv_cnt_q == $past(i_conv_samples))
        else $error("converter count not loaded");
    AST_CONV_LAST: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        conv_cnt_q == 3'h1 && rd_conv && !i_evt.conv_done
        |=> !src[pis_pkg::IRQ_CONV])
        else $error("converter source kept after last read");
    AST_PAR_HOLD: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        par_q && !rd_par |=> par_q)
        else $error("parallel source removed without read");
    AST_PAR_DROP: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        rd_par && !i_evt.par_done |=> !par_q)
        else $error("parallel source kept after read");

    AST_NO_CLEAR: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        s_clear_attempt(pis_pkg::IRQ_CAP) |=> pend_q[pis_pkg::IRQ_CAP])
        else $error("pending flag cleared while source live");
    AST_SET: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        src[pis_pkg::IRQ_PAR] |=> pend_q[pis_pkg::IRQ_PAR])
        else $error("pending flag not set by source");

    // ------------------------------------------------------------------
    // Checks: pending flags
    // ------------------------------------------------------------------
    // Flags follow live sources; a clear lands only once the source is gone
    for (genvar b = 0; b < pis_pkg::NUM_SRC; b = b + 1) begin : g_flag_chk
        AST_FLAG_SET: assert property (
            @(posedge i_ref_clk) disable iff (i_rst)
            src[b] |=> pend_q[b])
            else $error("pending flag not set by live source");
        AST_FLAG_KEEP: assert property (
            @(posedge i_ref_clk) disable iff (i_rst)
            s_clear_attempt(b) |=> pend_q[b])
            else $error("pending flag cleared while source live");
        AST_FLAG_CLEAR: assert property (
            @(posedge i_ref_clk) disable iff (i_rst)
            wr_clr && i_bus.wdata[b] && !src[b] |=> !pend_q[b])
            else $error("pending flag kept after clear");
    end

endmodule : pis_irq_sources

// ==== tb/pis_sw_agent.sv ====
// Servicing software model: register bus master for the irq block
`timescale 1ns/1ps
module pis_sw_agent (
    input wire logic i_ref_clk,
    input wire logic [31:0] i_rdata,
    output pis_pkg::pis_bus_req_t o_bus
);
    initial o_bus = '0;

    // ------------------------------------------------------------
    // Bus cycles, entered just after a rising edge
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_ref_clk);
        o_bus.wr <= 1'b0;
        @(posedge i_ref_clk);
    endtask : wr

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        o_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge i_ref_clk);
        o_bus.rd <= 1'b0;
        @(posedge i_ref_clk);
        d = i_rdata;
    endtask : rd

    // Condition removed by data accesses before any flag clear
    task automatic drain(input logic [7:0] a, input int n);
        logic [31:0] d;
        repeat (n) rd(a, d);
    endtask : drain
endmodule : pis_sw_agent

// ==== tb/persistent_irq_sources_tb.sv ====
// Self-checking bench for the persistent interrupt sources
`timescale 1ns/1ps
module persistent_irq_sources_tb;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    pis_pkg::pis_bus_req_t bus;
    pis_pkg::pis_hw_evt_t evt = '0;
    logic [2:0] smp = 3'h0;
    logic [31:0] rdata;
    logic irq;
    logic [31:0] lfsr = 32'hea492db6;
    logic [7:0] rda [5] = '{pis_pkg::ADDR_CAP_BUF, pis_pkg::ADDR_SYNC_BUF,
        pis_pkg::ADDR_ASYNC_RX, pis_pkg::ADDR_CONV_RES,
        pis_pkg::ADDR_PAR_DATA};
    int rix [5] = '{0, 1, 3, 5, 6};
    int bad_count = 0;
    int total_checks = 0;
    int cnt [6] = '{default: 0};
    int ctrl = 0;
    int en = 0;
    int pend = 0;
    int par = 0;

    always #50 i_ref_clk = ~i_ref_clk;

    pis_irq_sources DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bus(bus),
        .o_rdata(rdata), .i_evt(evt), .i_conv_samples(smp), .o_irq(irq));
    pis_sw_agent sw (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .o_bus(bus));

    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    function automatic int src();
        int a;
        a = ctrl >> 10 & 1;
        return int'(cnt[0] > (ctrl & 3)) |
            int'(cnt[1] > (ctrl >> 2 & 3)) << 1 |
            int'(4 - cnt[2] > (ctrl >> 4 & 3)) << 2 |
            int'(a && cnt[3] > (ctrl >> 6 & 3)) << 3 |
            int'(a && 4 - cnt[4] > (ctrl >> 8 & 3)) << 4 |
            int'(cnt[5] != 0) << 5 | par << 6;
    endfunction : src

    // Counts saturate, so stray pops at empty are harmless
    function automatic void bump(input int k, input int d);
        cnt[k] = cnt[k] + d < 0 ? 0 : cnt[k] + d > 4 ? 4 : cnt[k] + d;
    endfunction : bump

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_irq(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t irq got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_irq

    // ------------------------------------------------------------
    // Stimulus and comparison
    // ------------------------------------------------------------
    task automatic fire(input int k, input int n);
        evt <= 7'(1 << (6 - k));
        smp <= 3'(n);
        @(posedge i_ref_clk);
        evt <= '0;
        @(posedge i_ref_clk);
        if (k < 5) bump(k, (k == 2 || k == 4) ? -1 : 1);
        else if (k == 5) cnt[5] = n;
        else par = 1;
    endtask : fire

    task automatic clr(input logic [31:0] m);
        sw.wr(pis_pkg::ADDR_IRQ_CLR, m);
        pend &= ~int'(m[6:0]);
    endtask : clr

    task automatic verify();
        logic [31:0] d;
        int lv;
        lv = 0;
        pend |= src();
        for (int k = 0; k < 6; k++) lv |= cnt[k] << (3 * k);
        sw.rd(pis_pkg::ADDR_STATUS, d);
        chk_reg(d, 32'(pend));
        sw.rd(pis_pkg::ADDR_LEVELS, d);
        chk_reg(d, 32'(lv));
        chk_irq(irq, |(pend & en));
    endtask : verify

    task automatic step();
        logic [31:0] d;
        int k;
        lfsr = nxt(lfsr);
        k = int'(lfsr[10:8]) % 7;
        case (lfsr[2:0])
            3'h0, 3'h1: fire(k, int'(lfsr[15:13]) % 5);
            3'h2: begin
                k = k % 5;
                sw.rd(rda[k], d);
                chk_reg(d, 32'h0);
                if (rix[k] == 6) par = 0;
                else bump(rix[k], -1);
            end
            3'h3: begin
                sw.wr(lfsr[8] ? pis_pkg::ADDR_ASYNC_TX
                    : pis_pkg::ADDR_SYNC_BUF, lfsr);
                bump(lfsr[8] ? 4 : 2, 1);
            end
            3'h4: begin
                ctrl = int'(lfsr[26:16]);
                sw.wr(pis_pkg::ADDR_CTRL, 32'(ctrl));
            end
            3'h5: clr(lfsr);
            3'h6: begin
                en = int'(lfsr[22:16]);
                sw.wr(pis_pkg::ADDR_IRQ_EN, 32'(en));
            end
            default: begin
                sw.wr(pis_pkg::ADDR_STATUS, lfsr);
                sw.rd(8'h2c, d);
                chk_reg(d, 32'h0);
            end
        endcase
        verify();
    endtask : step

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        logic [31:0] d;
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        verify();
        sw.rd(pis_pkg::ADDR_CTRL, d);
        chk_reg(d, 32'h0);
        ctrl = 'h400;
        sw.wr(pis_pkg::ADDR_CTRL, 32'h400);
        verify();
        // Flag clear while capture entries remain must not stick
        repeat (2) fire(0, 0);
        clr(32'h1);
        verify();
        sw.drain(pis_pkg::ADDR_CAP_BUF, 2);
        bump(0, -2);
        clr(32'h1);
        verify();
        repeat (250) step();
        end_of_test();
    end

    // Random phase needs about 1600 cycles; far margin before giving up
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        bad_count++;
        end_of_test();
    end
endmodule : persistent_irq_sources_tb
